// ---- design/dpll_state_pkg.sv ----
package dpll_state_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned CLK_NS = 40;
	localparam logic [1:0] SEL_NORMAL = 2'h0;
	localparam logic [1:0] SEL_HOLD = 2'h1;
	localparam logic [1:0] SEL_FREE = 2'h2;
	localparam logic [1:0] RATE_8K = 2'h1;
	localparam logic [1:0] RATE_1544 = 2'h2;
	localparam logic [1:0] RATE_2048 = 2'h3;
	localparam int unsigned FRAME_HZ = 8000;
	localparam int unsigned FRAME_CYC = CLK_HZ / FRAME_HZ;
	localparam int unsigned STORE_MS = 30;
	localparam int unsigned STORE_FRAMES = STORE_MS * FRAME_HZ / 1000;
	localparam int unsigned TIE_CLEAR_NS = 300;
	localparam int unsigned TIE_CLEAR_CYC = (TIE_CLEAR_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SLEW_NS = 5;
	localparam int unsigned SLEW_CYC = (SLEW_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned LOCK_S = 30;
	localparam int unsigned LOCK_FRAMES = LOCK_S * FRAME_HZ;
	localparam int unsigned FAST_LOCK_MS = 500;
	localparam int unsigned FAST_LOCK_FRAMES = FAST_LOCK_MS * FRAME_HZ / 1000;
	localparam int unsigned PER_8K = CLK_HZ / 8000;
	localparam int unsigned PER_1544 = 16;
	localparam int unsigned PER_2048 = 12;
	localparam int unsigned CAP_PCT = 3;
	localparam int unsigned LOSS_CYC = 2 * PER_8K;
	localparam logic [23:0] FREQ_NOMINAL = 24'h800000;
	localparam int unsigned FRAME_PULSE_CYC = 3;
	typedef enum logic [2:0] {
		ST_NORMAL = 3'h1,
		ST_AUTO_HOLD = 3'h2,
		ST_HOLD = 3'h4
	} op_state_t;
endpackage

// ---- design/ref_validity_check.sv ----
`timescale 1ns/1ps
module ref_validity_check (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ref_fall_in,
	input wire logic [15:0] nominal_period_in,
	output logic valid_out
);
	logic [15:0] count_reg;
	logic valid_reg;
	wire [15:0] margin = (nominal_period_in * 16'(dpll_state_pkg::CAP_PCT)) / 16'd100 + 16'h1;
	wire [15:0] lo = nominal_period_in - margin;
	wire [15:0] hi = nominal_period_in + margin;
	wire lost = (count_reg >= 16'(dpll_state_pkg::LOSS_CYC));
	wire in_range = (count_reg >= lo) && (count_reg <= hi);
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			count_reg <= 16'h0;
			valid_reg <= 1'b0;
		end else if (ref_fall_in) begin
			count_reg <= 16'h1;
			valid_reg <= in_range;
		end else if (lost) begin
			valid_reg <= 1'b0;
		end else begin
			count_reg <= count_reg + 16'h1;
		end
	end
	assign valid_out = valid_reg;
endmodule

// ---- design/dpll_state_and_tie_control.sv ----
`timescale 1ns/1ps
module dpll_state_and_tie_control (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic op_select_low_in,
	input wire logic op_select_high_in,
	input wire logic phase_hitless_enable_in,
	input wire logic fast_lock_select_in,
	input wire logic ref_rate_select_low_in,
	input wire logic ref_rate_select_high_in,
	input wire logic tie_clear_n_in,
	input wire logic ref_in,
	input wire logic master_osc_input_in,
	input wire logic [15:0] feedback_phase_in,
	input wire logic [23:0] loop_freq_word_in,
	output logic frame_pulse_8k_high_out,
	output logic tracking_mode_flag_out,
	output logic memory_hold_flag_out,
	output logic autonomous_run_flag_out,
	output logic lock_flag_out,
	output logic tie_active_out,
	output logic [15:0] tie_offset_out,
	output logic [15:0] virtual_ref_phase_out,
	output logic [23:0] osc_freq_word_out,
	output logic use_master_osc_out,
	output logic slew_limit_out,
	output logic [1:0] ref_rate_out
);
	// Pin synchronisers
	logic [1:0] sel_s1_reg, sel_s2_reg, rate_s1_reg, rate_s2_reg;
	logic ref_s1_reg, ref_s2_reg, ref_d_reg;
	logic phase_hitless_enable_s1_reg, phase_hitless_enable_s2_reg, fast_lock_select_s1_reg, fast_lock_select_s2_reg;
	logic tie_clear_s1_reg, tie_clear_s2_reg, osc_s1_reg, osc_s2_reg;
	always_ff @(posedge sys_clk_in) begin
		sel_s1_reg <= {op_select_high_in, op_select_low_in};
		sel_s2_reg <= sel_s1_reg;
		rate_s1_reg <= {ref_rate_select_high_in, ref_rate_select_low_in};
		rate_s2_reg <= rate_s1_reg;
		ref_s1_reg <= ref_in;
		ref_s2_reg <= ref_s1_reg;
		ref_d_reg <= ref_s2_reg;
		phase_hitless_enable_s1_reg <= phase_hitless_enable_in;
		phase_hitless_enable_s2_reg <= phase_hitless_enable_s1_reg;
		fast_lock_select_s1_reg <= fast_lock_select_in;
		fast_lock_select_s2_reg <= fast_lock_select_s1_reg;
		tie_clear_s1_reg <= tie_clear_n_in;
		tie_clear_s2_reg <= tie_clear_s1_reg;
		osc_s1_reg <= master_osc_input_in;
		osc_s2_reg <= osc_s1_reg;
	end

	// Rate caught after reset release
	logic [1:0] rate_reg;
	logic rate_taken_reg;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			rate_reg <= dpll_state_pkg::RATE_8K;
			rate_taken_reg <= 1'b0;
		end else if (!rate_taken_reg) begin
			rate_reg <= rate_s2_reg;
			rate_taken_reg <= 1'b1;
		end
	end
	wire [15:0] nominal_period =
		(rate_reg == dpll_state_pkg::RATE_2048) ? 16'(dpll_state_pkg::PER_2048) :
		(rate_reg == dpll_state_pkg::RATE_1544) ? 16'(dpll_state_pkg::PER_1544) :
		16'(dpll_state_pkg::PER_8K);
	wire rate_reserved = (rate_reg == 2'h0);
	wire ref_fall = ref_d_reg && !ref_s2_reg;

	// Frame pulse divider
	logic [12:0] frame_cnt_reg;
	logic frame_out_reg;
	wire frame_wrap = (frame_cnt_reg == 13'(dpll_state_pkg::FRAME_CYC - 1));
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			frame_cnt_reg <= 13'h0;
			frame_out_reg <= 1'b0;
		end else begin
			frame_cnt_reg <= frame_wrap ? 13'h0 : frame_cnt_reg + 13'h1;
			frame_out_reg <= (frame_cnt_reg < 13'(dpll_state_pkg::FRAME_PULSE_CYC));
		end
	end
	wire frame_edge = frame_wrap; // Pulse rises two cycles after the wrap cycle

	logic ref_valid_raw;
	ref_validity_check u_valid (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.ref_fall_in(ref_fall),
		.nominal_period_in(nominal_period),
		.valid_out(ref_valid_raw)
	);
	wire ref_valid = ref_valid_raw && !rate_reserved;

	// Mode state machine
	dpll_state_pkg::op_state_t state_reg, state_next;
	logic free_reg, free_next;
	wire [1:0] sel = sel_s2_reg;
	always_comb begin
		state_next = state_reg;
		free_next = free_reg;
		if (frame_edge) begin
			case (sel)
				dpll_state_pkg::SEL_FREE: free_next = 1'b1;
				dpll_state_pkg::SEL_HOLD: begin
					free_next = 1'b0;
					state_next = dpll_state_pkg::ST_HOLD;
				end
				dpll_state_pkg::SEL_NORMAL: begin
					free_next = 1'b0;
					case (state_reg)
						dpll_state_pkg::ST_NORMAL:
							if (!ref_valid) state_next = dpll_state_pkg::ST_AUTO_HOLD;
						dpll_state_pkg::ST_AUTO_HOLD:
							if (ref_valid) state_next = dpll_state_pkg::ST_NORMAL;
						dpll_state_pkg::ST_HOLD: state_next = dpll_state_pkg::ST_NORMAL;
						default: state_next = dpll_state_pkg::ST_NORMAL;
					endcase
				end
				default: begin
				end
			endcase
			if (free_next) state_next = dpll_state_pkg::ST_NORMAL;
		end
	end
	wire is_free = free_reg;
	wire is_normal = !free_reg && state_reg == dpll_state_pkg::ST_NORMAL;
	wire is_hold = !free_reg && state_reg != dpll_state_pkg::ST_NORMAL;
	wire nx_normal = !free_next && state_next == dpll_state_pkg::ST_NORMAL;
	wire changed = (state_next != state_reg) || (free_next != free_reg);
	wire to_normal_from_hold = is_hold && nx_normal;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_reg <= dpll_state_pkg::ST_NORMAL;
			free_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			free_reg <= free_next;
		end
	end

	// TIE enable
	logic tie_on_reg;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) tie_on_reg <= 1'b0;
		else if (changed && to_normal_from_hold) tie_on_reg <= phase_hitless_enable_s2_reg;
		else if (changed) tie_on_reg <= 1'b0;
	end

	// Tie clear low-width check
	logic [3:0] tie_clear_cnt_reg;
	wire tie_clear_hit = (tie_clear_cnt_reg == 4'(dpll_state_pkg::TIE_CLEAR_CYC - 1)) && !tie_clear_s2_reg;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || tie_clear_s2_reg) tie_clear_cnt_reg <= 4'h0;
		else if (!tie_clear_hit && tie_clear_cnt_reg != 4'hf) tie_clear_cnt_reg <= tie_clear_cnt_reg + 4'h1;
	end

	// Offset measure and store
	logic [15:0] offset_reg, vref_reg;
	wire [15:0] measured = {3'h0, frame_cnt_reg} - feedback_phase_in;
	// Capture beats a clear landing in the same cycle
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) offset_reg <= 16'h0;
		else if (changed && to_normal_from_hold && phase_hitless_enable_s2_reg) offset_reg <= measured;
		else if (tie_clear_hit) offset_reg <= 16'h0;
	end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) vref_reg <= 16'h0;
		else if (ref_fall) vref_reg <= {3'h0, frame_cnt_reg} - (tie_on_reg ? offset_reg : 16'h0);
	end

	// Slew limit: on in normal tracking when not fast locking
	wire slew_on = is_normal && !fast_lock_select_s2_reg;

	// Lock timer
	logic [17:0] lock_cnt_reg;
	wire [17:0] lock_goal = fast_lock_select_s2_reg ? 18'(dpll_state_pkg::FAST_LOCK_FRAMES) :
		18'(dpll_state_pkg::LOCK_FRAMES);
	wire locked = is_normal && ref_valid && lock_cnt_reg >= lock_goal;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !is_normal || !ref_valid) lock_cnt_reg <= 18'h0;
		else if (frame_edge && lock_cnt_reg < lock_goal) lock_cnt_reg <= lock_cnt_reg + 18'h1;
	end

	// Holdover storage, two slots
	logic [23:0] slot_reg [2];
	logic slot_sel_reg, store_armed_reg;
	logic [7:0] store_cnt_reg;
	logic [23:0] freq_reg;
	wire store_tick = frame_edge && store_cnt_reg == 8'(dpll_state_pkg::STORE_FRAMES - 1);
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !locked) begin
			store_cnt_reg <= 8'h0;
		end else if (frame_edge) begin
			store_cnt_reg <= store_tick ? 8'h0 : store_cnt_reg + 8'h1;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			slot_reg[0] <= dpll_state_pkg::FREQ_NOMINAL;
			slot_reg[1] <= dpll_state_pkg::FREQ_NOMINAL;
			slot_sel_reg <= 1'b0;
			store_armed_reg <= 1'b0;
		end else if (locked && store_tick) begin
			slot_reg[slot_sel_reg] <= loop_freq_word_in;
			slot_sel_reg <= !slot_sel_reg;
			store_armed_reg <= 1'b1;
		end
	end
	// Older slot is the one about to be overwritten next
	wire [23:0] older = slot_reg[slot_sel_reg];
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) freq_reg <= dpll_state_pkg::FREQ_NOMINAL;
		else if (is_normal && !free_next && state_next != dpll_state_pkg::ST_NORMAL)
			freq_reg <= store_armed_reg ? older : freq_reg;
		else if (is_normal) freq_reg <= loop_freq_word_in;
		else if (is_free) freq_reg <= dpll_state_pkg::FREQ_NOMINAL;
	end

	// Output registers
	logic trk_reg, hold_reg, free_flag_reg, lock_reg, osc_reg;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			trk_reg <= 1'b0;
			hold_reg <= 1'b0;
			free_flag_reg <= 1'b0;
			lock_reg <= 1'b0;
			osc_reg <= 1'b0;
		end else begin
			trk_reg <= is_normal;
			hold_reg <= is_hold;
			free_flag_reg <= is_free;
			lock_reg <= locked;
			osc_reg <= is_free || is_hold;
		end
	end

	assign frame_pulse_8k_high_out = frame_out_reg;
	assign tracking_mode_flag_out = trk_reg;
	assign memory_hold_flag_out = hold_reg;
	assign autonomous_run_flag_out = free_flag_reg;
	assign lock_flag_out = lock_reg;
	assign tie_active_out = tie_on_reg;
	assign tie_offset_out = offset_reg;
	assign virtual_ref_phase_out = vref_reg;
	assign osc_freq_word_out = freq_reg;
	assign use_master_osc_out = osc_reg;
	assign slew_limit_out = slew_on;
	assign ref_rate_out = rate_reg;
endmodule

// ---- verif/ref_source_model.sv ----
`timescale 1ns/1ps
module ref_source_model (
	input wire logic run_in,
	input wire logic [15:0] half_ns_in,
	output logic ref_out
);
	// An absent reference leaves the line standing low
	always begin
		if (run_in) begin
			#(half_ns_in) ref_out = 1'b1;
			#(half_ns_in) ref_out = 1'b0;
		end else begin
			ref_out = 1'b0;
			// Restart edges well clear of the sampling clock edge
			@(posedge run_in);
			#5;
		end
	end
endmodule

// ---- verif/dpll_state_and_tie_control_properties.sv ----
`timescale 1ns/1ps
module dpll_state_and_tie_control_properties (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic fast_lock_select_in,
	input wire logic tie_clear_n_in,
	input wire logic frame_pulse_8k_high_out,
	input wire logic tracking_mode_flag_out,
	input wire logic memory_hold_flag_out,
	input wire logic autonomous_run_flag_out,
	input wire logic tie_active_out,
	input wire logic [15:0] tie_offset_out,
	input wire logic use_master_osc_out,
	input wire logic slew_limit_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	property p_one_mode;
		$onehot0({tracking_mode_flag_out, memory_hold_flag_out, autonomous_run_flag_out});
	endproperty
	a_one_mode: assert property (p_one_mode) else $error("two mode flags high");
	property p_frame_width;
		$rose(frame_pulse_8k_high_out) |-> frame_pulse_8k_high_out[*3] ##1 !frame_pulse_8k_high_out;
	endproperty
	a_frame_width: assert property (p_frame_width) else $error("frame pulse width");
	property p_change_at_frame;
		($changed(memory_hold_flag_out) || $changed(autonomous_run_flag_out)) |->
			(frame_pulse_8k_high_out || $past(frame_pulse_8k_high_out));
	endproperty
	a_change_at_frame: assert property (p_change_at_frame) else $error("mode moved off frame");
	property p_free_osc;
		autonomous_run_flag_out && $past(autonomous_run_flag_out) |-> $past(use_master_osc_out);
	endproperty
	a_free_osc: assert property (p_free_osc) else $error("freerun not on oscillator");
	property p_tie_off;
		$rose(memory_hold_flag_out) || $rose(autonomous_run_flag_out) |-> !tie_active_out;
	endproperty
	a_tie_off: assert property (p_tie_off) else $error("tie kept on mode change");
	property p_tie_on;
		$rose(tie_active_out) |=> tracking_mode_flag_out && $past(memory_hold_flag_out);
	endproperty
	a_tie_on: assert property (p_tie_on) else $error("tie enabled off hold exit");
	property p_slew;
		(tracking_mode_flag_out && $stable(fast_lock_select_in))[*5] |->
			$past(slew_limit_out) == !fast_lock_select_in;
	endproperty
	a_slew: assert property (p_slew) else $error("slew limit wrong");
	property p_tie_clear;
		!tie_clear_n_in[*8] |-> ##[0:4] tie_offset_out == 16'h0;
	endproperty
	a_tie_clear: assert property (p_tie_clear) else $error("offset not cleared");
endmodule
bind dpll_state_and_tie_control dpll_state_and_tie_control_properties chk_i (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .fast_lock_select_in(fast_lock_select_in),
	.tie_clear_n_in(tie_clear_n_in), .frame_pulse_8k_high_out(frame_pulse_8k_high_out),
	.tracking_mode_flag_out(tracking_mode_flag_out), .memory_hold_flag_out(memory_hold_flag_out),
	.autonomous_run_flag_out(autonomous_run_flag_out), .tie_active_out(tie_active_out),
	.tie_offset_out(tie_offset_out), .use_master_osc_out(use_master_osc_out),
	.slew_limit_out(slew_limit_out));

// ---- verif/dpll_state_and_tie_control_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module dpll_state_and_tie_control_test;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [1:0] op_sel = dpll_state_pkg::SEL_FREE;
	logic [1:0] rate_sel = dpll_state_pkg::RATE_2048;
	logic hitless_en = 1'b0;
	logic fast_lock = 1'b0;
	logic tie_clear_n = 1'b1;
	logic ref_run = 1'b0;
	logic [15:0] ref_half = 16'h00f0;
	logic ref_line, frame, tracking, hold, free, tie_act, use_osc, slew, lock;
	logic [15:0] tie_off, vref;
	logic [23:0] freq_word;
	logic [23:0] loop_word = 24'h0;
	logic [1:0] rate_seen;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	always #20 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) loop_word <= loop_word + 24'h1;
	ref_source_model ref_source_model_i (.run_in(ref_run), .half_ns_in(ref_half), .ref_out(ref_line));
	dpll_state_and_tie_control dpll_state_and_tie_control_i (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .op_select_low_in(op_sel[0]),
		.op_select_high_in(op_sel[1]), .phase_hitless_enable_in(hitless_en),
		.fast_lock_select_in(fast_lock), .ref_rate_select_low_in(rate_sel[0]),
		.ref_rate_select_high_in(rate_sel[1]), .tie_clear_n_in(tie_clear_n), .ref_in(ref_line),
		.master_osc_input_in(loop_word[0]), .feedback_phase_in(16'h1234),
		.loop_freq_word_in(loop_word),
		.frame_pulse_8k_high_out(frame), .tracking_mode_flag_out(tracking),
		.memory_hold_flag_out(hold), .autonomous_run_flag_out(free), .lock_flag_out(lock),
		.tie_active_out(tie_act), .tie_offset_out(tie_off), .virtual_ref_phase_out(vref),
		.osc_freq_word_out(freq_word), .use_master_osc_out(use_osc), .slew_limit_out(slew),
		.ref_rate_out(rate_seen));
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_in);
		#2;
	endtask
	task automatic frames(input int n);
		repeat (n) begin
			while (frame) step(1);
			while (!frame) step(1);
		end
		step(4);
	endtask
	task automatic reset_dut();
		rst_in = 1'b1;
		step(8);
		rst_in = 1'b0;
		step(4);
	endtask
	task automatic t_freerun_start();
		reset_dut();
		frames(2);
		`CHK("flags", 3'h1, {tracking, hold, free})
		`CHK("use_osc", 1'b1, use_osc)
		`CHK("freq", dpll_state_pkg::FREQ_NOMINAL, freq_word)
		`CHK("lock", 1'b0, lock)
		`CHK("rate", dpll_state_pkg::RATE_2048, rate_seen)
		$display("test freerun_start done");
	endtask
	task automatic t_hold();
		logic [23:0] held_word;
		ref_run = 1'b1;
		op_sel = dpll_state_pkg::SEL_NORMAL;
		frames(2);
		`CHK("flags", 3'h4, {tracking, hold, free})
		`CHK("tie", 1'b0, tie_act)
		step(10);
		op_sel = dpll_state_pkg::SEL_HOLD;
		step(200);
		`CHK("flags", 3'h4, {tracking, hold, free})
		frames(1);
		`CHK("flags", 3'h2, {tracking, hold, free})
		held_word = freq_word;
		op_sel = 2'h3;
		frames(2);
		`CHK("flags", 3'h2, {tracking, hold, free})
		`CHK("freq", held_word, freq_word)
		$display("test hold done");
	endtask
	task automatic t_back_tie();
		hitless_en = 1'b1;
		op_sel = dpll_state_pkg::SEL_NORMAL;
		frames(1);
		`CHK("flags", 3'h4, {tracking, hold, free})
		`CHK("tie", 1'b1, tie_act)
		`CHK("offset_held", 1'b1, tie_off != 16'h0)
		fast_lock = 1'b1;
		step(10);
		`CHK("slew", 1'b0, slew)
		fast_lock = 1'b0;
		step(10);
		`CHK("slew", 1'b1, slew)
		`CHK("vref", 1'b1, (vref + tie_off) < 16'(dpll_state_pkg::FRAME_CYC))
		tie_clear_n = 1'b0;
		step(8);
		tie_clear_n = 1'b1;
		step(4);
		`CHK("offset", 16'h0000, tie_off)
		$display("test back_tie done");
	endtask
	task automatic t_auto_hold();
		ref_run = 1'b0;
		frames(4);
		`CHK("flags", 3'h2, {tracking, hold, free})
		`CHK("tie", 1'b0, tie_act)
		hitless_en = 1'b0;
		ref_run = 1'b1;
		frames(3);
		`CHK("flags", 3'h4, {tracking, hold, free})
		`CHK("tie", 1'b0, tie_act)
		ref_half = 16'h0190;
		frames(4);
		`CHK("flags", 3'h2, {tracking, hold, free})
		ref_half = 16'h00f0;
		hitless_en = 1'b1;
		frames(3);
		`CHK("flags", 3'h4, {tracking, hold, free})
		`CHK("tie", 1'b1, tie_act)
		$display("test auto_hold done");
	endtask
	task automatic t_rate();
		rate_sel = dpll_state_pkg::RATE_8K;
		step(4);
		`CHK("rate", dpll_state_pkg::RATE_2048, rate_seen)
		op_sel = dpll_state_pkg::SEL_FREE;
		reset_dut();
		`CHK("rate", dpll_state_pkg::RATE_8K, rate_seen)
		$display("test rate done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Run needs about 22 frames of 3125 cycles
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		t_freerun_start();
		t_hold();
		t_back_tie();
		t_auto_hold();
		t_rate();
		tally_and_finish();
	end
endmodule
